// ===== core/bridge_pkg.sv
// bridge_pkg: register map, field positions and reset values of the
// non-transparent bridge address translation block.
// assumes an 8-bit byte register address, bit 7 selecting the endpoint.
package bridge_pkg;
  localparam int unsigned SIDES = 2;
  localparam int unsigned WINDOWS = 4;
  localparam int unsigned BASES = 5;
  localparam int unsigned ENTRIES = 16;
  localparam logic SIDE_INT = 1'b0;
  localparam logic SIDE_EXT = 1'b1;
  localparam int unsigned SIDE_BIT = 7;
  // per-endpoint byte offsets (bit 7 of the address picks the endpoint)
  localparam logic [6:0] OFS_CMD = 7'h00;
  localparam logic [6:0] OFS_STATUS = 7'h04;
  localparam logic [6:0] OFS_TBL_INDEX = 7'h08;
  localparam logic [6:0] OFS_TBL_DATA = 7'h0C;
  localparam logic [6:0] OFS_OWN_ID = 7'h10;
  localparam logic [6:0] OFS_PORT_CMD = 7'h14;
  localparam logic [6:0] OFS_SETUP = 7'h20;
  localparam logic [6:0] OFS_BASE = 7'h30;
  localparam logic [6:0] OFS_TBASE = 7'h48;
  localparam logic [6:0] OFS_TLIMIT = 7'h58;
  // command bits
  localparam int unsigned CMD_IO_EN = 0;
  localparam int unsigned CMD_MEM_EN = 1;
  localparam int unsigned CMD_MASTER_EN = 2;
  localparam int unsigned CMD_ERR_MSG_EN = 8;
  // status bits
  localparam int unsigned STS_TBL_ACCESS = 0;
  localparam int unsigned STS_FWD_MISS = 1;
  localparam int unsigned STS_REV_MISS = 2;
  localparam int unsigned STS_WIN_MISS = 3;
  localparam int unsigned STS_UNSUPPORTED = 4;
  localparam int unsigned STS_W = 5;
  // window setup fields
  localparam int unsigned SETUP_IO = 0;
  localparam int unsigned SETUP_PREFETCH = 1;
  localparam int unsigned SETUP_PAIR = 2;
  localparam int unsigned SETUP_SIZE_LO = 3;
  localparam int unsigned SIZE_W = 6;
  localparam int unsigned XLAT_SHIFT = 4;
  // mapping table entry
  localparam int unsigned ENT_VALID = 0;
  localparam int unsigned ENT_ID_LO = 16;
  localparam logic [31:0] ENT_MASK = 32'hFFFF0001;
  localparam logic [3:0] BE_DWORD = 4'hF;
  // reset values
  localparam logic [31:0] CMD_RST = 32'h00000000;
  localparam logic [31:0] WIN_RST = 32'h00000000;
  localparam logic [15:0] OWN_ID_RST = 16'h0000;
  localparam logic PORT_MASTER_RST = 1'b0;
endpackage

// ===== core/map_table_if.sv
// map_table_if: ports of the two 16-entry mapping tables.
// assumes one controller and one table on the same clock.
`timescale 1ns/100ps
interface map_table_if;
  logic wr_en;
  logic wr_side;
  logic [3:0] wr_idx;
  logic [31:0] wr_data;
  logic [1:0][3:0] sw_idx;
  logic [1:0][31:0] sw_data;
  logic srch_side;
  logic [15:0] srch_id;
  logic srch_hit;
  logic [3:0] srch_idx;
  logic cpl_side;
  logic [3:0] cpl_idx;
  logic [31:0] cpl_data;
  modport ctrl (output wr_en, wr_side, wr_idx, wr_data, sw_idx, srch_side, srch_id,
    cpl_side, cpl_idx, input sw_data, srch_hit, srch_idx, cpl_data);
  modport table_end (input wr_en, wr_side, wr_idx, wr_data, sw_idx, srch_side,
    srch_id, cpl_side, cpl_idx, output sw_data, srch_hit, srch_idx, cpl_data);
endinterface

// ===== core/map_table.sv
// map_table: mapping tables of both endpoints with registered reads.
// assumes write and lookup requests arrive on mclk.
`timescale 1ns/100ps
module map_table (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  // table port
  map_table_if.table_end tbl
);
  logic [31:0] mem [bridge_pkg::SIDES][bridge_pkg::ENTRIES];
  logic next_hit;
  logic [3:0] next_idx;

  // invalid entries read as zero
  function automatic logic [31:0] shown(input logic [31:0] e);
    shown = e[bridge_pkg::ENT_VALID] ? (e & bridge_pkg::ENT_MASK) : 32'h00000000;
  endfunction

  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int s = 0; s < bridge_pkg::SIDES; s++) begin
        for (int i = 0; i < bridge_pkg::ENTRIES; i++) begin
          mem[s][i][bridge_pkg::ENT_VALID] <= 1'b0;
        end
      end
    end else if (ce && tbl.wr_en) begin
      mem[tbl.wr_side][tbl.wr_idx] <= tbl.wr_data & bridge_pkg::ENT_MASK;
    end
  end

  // software view, bypassing a write in the same cycle
  always_ff @(posedge mclk) begin
    for (int s = 0; s < bridge_pkg::SIDES; s++) begin
      if (srst) begin
        tbl.sw_data[s] <= 32'h00000000;
      end else if (ce) begin
        if (tbl.wr_en && tbl.wr_side == 1'(s) && tbl.wr_idx == tbl.sw_idx[s]) begin
          tbl.sw_data[s] <= shown(tbl.wr_data);
        end else begin
          tbl.sw_data[s] <= shown(mem[s][tbl.sw_idx[s]]);
        end
      end
    end
  end

  // associative search, lowest index wins
  always_comb begin
    next_hit = 1'b0;
    next_idx = 4'h0;
    for (int i = bridge_pkg::ENTRIES - 1; i >= 0; i--) begin
      if (mem[tbl.srch_side][i][bridge_pkg::ENT_VALID] &&
          mem[tbl.srch_side][i][31:16] == tbl.srch_id) begin
        next_hit = 1'b1;
        next_idx = 4'(i);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      tbl.srch_hit <= 1'b0;
      tbl.srch_idx <= 4'h0;
      tbl.cpl_data <= 32'h00000000;
    end else if (ce) begin
      tbl.srch_hit <= next_hit;
      tbl.srch_idx <= next_idx;
      tbl.cpl_data <= shown(mem[tbl.cpl_side][tbl.cpl_idx]);
    end
  end
endmodule

// ===== core/window_match.sv
// window_match: window compare, base/limit translation, registered result.
// assumes the window set of the receiving endpoint is presented.
`timescale 1ns/100ps
module window_match (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  // request
  input wire logic [63:0] addr,
  input wire logic is_io,
  // window set
  input wire logic [3:0][31:0] setup,
  input wire logic [3:0][31:0] base,
  input wire logic [3:0][31:0] tbase,
  input wire logic [3:0][31:0] tlimit,
  // result
  output logic hit,
  output logic [63:0] xaddr
);
  logic next_hit;
  logic [63:0] next_xaddr;

  // {hit within limit, translated address}
  function automatic logic [64:0] eval(input logic [5:0] size, input logic [63:0] a,
                                       input logic [63:0] b, input logic [63:0] t,
                                       input logic [63:0] l);
    logic [63:0] mask;
    logic [63:0] x;
    mask = ~((64'h1 << size) - 64'h1);
    x = t + (a & ~mask);
    eval = {((a & mask) == (b & mask)) && (x <= l), x};
  endfunction

  always_comb begin
    logic [64:0] r;
    logic pair;
    logic skip;
    logic [5:0] size;
    logic [63:0] b;
    logic [63:0] t;
    logic [63:0] l;
    r = '0;
    pair = 1'b0;
    skip = 1'b0;
    size = '0;
    b = '0;
    t = '0;
    l = '0;
    next_hit = 1'b0;
    next_xaddr = 64'h0;
    for (int w = 0; w < bridge_pkg::WINDOWS; w++) begin
      pair = (w % 2 == 0) && setup[w][bridge_pkg::SETUP_PAIR];
      skip = (w % 2 == 1) && setup[w ^ 1][bridge_pkg::SETUP_PAIR];
      size = setup[w][bridge_pkg::SETUP_SIZE_LO +: bridge_pkg::SIZE_W];
      b = pair ? {base[w ^ 1], base[w]} : {32'h0, base[w]};
      t = pair ? {tbase[w ^ 1], tbase[w][27:0], 4'h0} : {32'h0, tbase[w][27:0], 4'h0};
      l = pair ? {tlimit[w ^ 1], tlimit[w][27:0], 4'h0} : {32'h0, tlimit[w][27:0], 4'h0};
      r = eval(size, addr, b, t, l);
      if (!next_hit && !skip && size != 6'h0 && setup[w][bridge_pkg::SETUP_IO] == is_io &&
          (pair || addr[63:32] == 32'h0) && r[64]) begin
        next_hit = 1'b1;
        next_xaddr = r[63:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      hit <= 1'b0;
      xaddr <= 64'h0;
    end else if (ce) begin
      hit <= next_hit;
      xaddr <= next_xaddr;
    end
  end
endmodule

// ===== core/ntb_address_translation.sv
// ntb_address_translation: windows, mapping tables and id rewrite for
// both endpoints of the non-transparent bridge, with a register port.
// assumes tlp headers arrive on mclk; link_up comes from port c logic.
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps

module ntb_address_translation (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [3:0] reg_be,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // port c link state
  input wire logic link_up,
  // received tlp header
  input wire logic req_valid,
  input wire logic req_side,
  input wire logic req_io,
  input wire logic req_np,
  input wire logic req_cpl,
  input wire logic [63:0] req_addr,
  input wire logic [15:0] req_id,
  // forwarded tlp header
  output logic fwd_valid,
  output logic fwd_side,
  output logic fwd_cpl,
  output logic [63:0] fwd_addr,
  output logic [15:0] fwd_req_id,
  output logic [15:0] fwd_cpl_id,
  // error handling
  output logic ur_cpl_valid,
  output logic ur_side,
  output logic [15:0] ur_req_id,
  output logic err_msg,
  output logic uc_valid
);
  logic side_sel;
  logic [6:0] ofs;
  logic [1:0][31:0] cmd;
  logic port_master_en;
  logic [1:0][bridge_pkg::STS_W-1:0] status;
  logic [1:0][3:0] tbl_index;
  logic [1:0][15:0] own_id;
  logic [1:0][3:0][31:0] setup;
  logic [1:0][4:0][31:0] base;
  logic [1:0][3:0][31:0] tbase;
  logic [1:0][3:0][31:0] tlimit;
  logic link_q1;
  logic link_q2;
  logic s1_valid;
  logic s1_side;
  logic s1_io;
  logic s1_np;
  logic s1_cpl;
  logic [15:0] s1_id;
  logic win_hit;
  logic [63:0] win_xaddr;
  logic tbl_odd_access;
  logic [31:0] next_rdata;
  logic next_fwd;
  logic [63:0] next_addr;
  logic [15:0] next_req_id;
  logic [15:0] next_cpl_id;
  logic next_ur;
  logic next_uc;
  logic [bridge_pkg::STS_W-1:0] next_set;

  map_table_if tbl ();

  assign side_sel = reg_addr[bridge_pkg::SIDE_BIT];
  assign ofs = reg_addr[6:0];

  function automatic logic at(input logic [6:0] o, input logic [6:0] start, input int w);
    at = (o == 7'(start + 7'(w * 4)));
  endfunction

  // writable base bits for a window size
  function automatic logic [31:0] wmask(input logic [31:0] st);
    logic [5:0] size;
    size = st[bridge_pkg::SETUP_SIZE_LO +: bridge_pkg::SIZE_W];
    if (size == 6'h0) begin
      wmask = 32'hFFFFFFFF;
    end else if (size >= 6'h20) begin
      wmask = 32'h00000000;
    end else begin
      wmask = ~((32'h1 << size) - 32'h1);
    end
  endfunction

  // command, own id and port bridge command
  always_ff @(posedge mclk) begin
    if (srst) begin
      cmd <= {bridge_pkg::CMD_RST, bridge_pkg::CMD_RST};
      own_id <= {bridge_pkg::OWN_ID_RST, bridge_pkg::OWN_ID_RST};
      port_master_en <= bridge_pkg::PORT_MASTER_RST;
    end else if (ce && reg_wr) begin
      if (ofs == bridge_pkg::OFS_CMD) begin
        cmd[side_sel] <= reg_wdata;
      end
      if (ofs == bridge_pkg::OFS_OWN_ID) begin
        own_id[side_sel] <= reg_wdata[15:0];
      end
      if (ofs == bridge_pkg::OFS_PORT_CMD) begin
        port_master_en <= reg_wdata[bridge_pkg::CMD_MASTER_EN];
      end
    end
  end

  // window registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      setup <= '0;
      base <= '0;
      tbase <= '0;
      tlimit <= '0;
    end else if (ce && reg_wr) begin
      for (int w = 0; w < bridge_pkg::WINDOWS; w++) begin
        if (at(ofs, bridge_pkg::OFS_SETUP, w)) begin
          setup[side_sel][w] <= reg_wdata;
        end
        if (at(ofs, bridge_pkg::OFS_BASE, w)) begin
          base[side_sel][w] <= reg_wdata & wmask(setup[side_sel][w]);
        end
        if (at(ofs, bridge_pkg::OFS_TBASE, w)) begin
          tbase[side_sel][w] <= reg_wdata;
        end
        if (at(ofs, bridge_pkg::OFS_TLIMIT, w)) begin
          tlimit[side_sel][w] <= reg_wdata;
        end
      end
      if (at(ofs, bridge_pkg::OFS_BASE, bridge_pkg::BASES - 1)) begin
        base[side_sel][bridge_pkg::BASES-1] <= reg_wdata;
      end
    end
  end

  // table index and table access
  always_ff @(posedge mclk) begin
    if (srst) begin
      tbl_index <= '0;
    end else if (ce && reg_wr && ofs == bridge_pkg::OFS_TBL_INDEX) begin
      tbl_index[side_sel] <= reg_wdata[3:0];
    end
  end

  assign tbl_odd_access = (reg_wr || reg_rd) && ofs == bridge_pkg::OFS_TBL_DATA &&
                          reg_be != bridge_pkg::BE_DWORD;

  always_comb begin
    for (int s = 0; s < bridge_pkg::SIDES; s++) begin
      if (reg_wr && side_sel == 1'(s) && ofs == bridge_pkg::OFS_TBL_INDEX) begin
        tbl.sw_idx[s] = reg_wdata[3:0];
      end else begin
        tbl.sw_idx[s] = tbl_index[s];
      end
    end
  end

  assign tbl.wr_en = reg_wr && ofs == bridge_pkg::OFS_TBL_DATA &&
                     reg_be == bridge_pkg::BE_DWORD;
  assign tbl.wr_side = side_sel;
  assign tbl.wr_idx = tbl_index[side_sel];
  assign tbl.wr_data = reg_wdata;
  assign tbl.srch_side = req_side;
  assign tbl.srch_id = req_id;
  assign tbl.cpl_side = ~req_side;
  assign tbl.cpl_idx = req_id[3:0];

  map_table map_table_inst (
    .mclk(mclk),
    .srst(srst),
    .ce(ce),
    .tbl(tbl.table_end)
  );

  window_match window_match_inst (
    .mclk(mclk),
    .srst(srst),
    .ce(ce),
    .addr(req_addr),
    .is_io(req_io),
    .setup(setup[req_side]),
    .base(base[req_side][3:0]),
    .tbase(tbase[req_side]),
    .tlimit(tlimit[req_side]),
    .hit(win_hit),
    .xaddr(win_xaddr)
  );

  // register read data
  always_comb begin
    next_rdata = 32'h00000000;
    if (ofs == bridge_pkg::OFS_CMD) begin
      next_rdata = cmd[side_sel];
    end else if (ofs == bridge_pkg::OFS_STATUS) begin
      next_rdata = 32'(status[side_sel]);
    end else if (ofs == bridge_pkg::OFS_TBL_INDEX) begin
      next_rdata = 32'(tbl_index[side_sel]);
    end else if (ofs == bridge_pkg::OFS_TBL_DATA && reg_be == bridge_pkg::BE_DWORD) begin
      next_rdata = tbl.sw_data[side_sel];
    end else if (ofs == bridge_pkg::OFS_OWN_ID) begin
      next_rdata = 32'(own_id[side_sel]);
    end else if (ofs == bridge_pkg::OFS_PORT_CMD) begin
      next_rdata = 32'(port_master_en) << bridge_pkg::CMD_MASTER_EN;
    end
    for (int w = 0; w < bridge_pkg::WINDOWS; w++) begin
      if (at(ofs, bridge_pkg::OFS_SETUP, w)) begin
        next_rdata = setup[side_sel][w];
      end
      if (at(ofs, bridge_pkg::OFS_BASE, w)) begin
        next_rdata = base[side_sel][w];
      end
      if (at(ofs, bridge_pkg::OFS_TBASE, w)) begin
        next_rdata = tbase[side_sel][w];
      end
      if (at(ofs, bridge_pkg::OFS_TLIMIT, w)) begin
        next_rdata = tlimit[side_sel][w];
      end
    end
    if (at(ofs, bridge_pkg::OFS_BASE, bridge_pkg::BASES - 1)) begin
      next_rdata = base[side_sel][bridge_pkg::BASES-1];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      reg_rdata <= 32'h00000000;
    end else if (ce && reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // port c link state into mclk
  always_ff @(posedge mclk) begin
    if (srst) begin
      link_q1 <= 1'b0;
      link_q2 <= 1'b0;
    end else if (ce) begin
      link_q1 <= link_up;
      link_q2 <= link_q1;
    end
  end

  // header stage beside the window and table lookups
  always_ff @(posedge mclk) begin
    if (srst) begin
      s1_valid <= 1'b0;
      s1_side <= 1'b0;
      s1_io <= 1'b0;
      s1_np <= 1'b0;
      s1_cpl <= 1'b0;
      s1_id <= 16'h0000;
    end else if (ce) begin
      s1_valid <= req_valid;
      s1_side <= req_side;
      s1_io <= req_io;
      s1_np <= req_np;
      s1_cpl <= req_cpl;
      s1_id <= req_id;
    end
  end

  // routing decision
  always_comb begin
    logic dst;
    logic link_ok;
    logic access_ok;
    logic master_ok;
    dst = ~s1_side;
    link_ok = s1_side == bridge_pkg::SIDE_EXT || link_q2;
    access_ok = s1_io ? cmd[s1_side][bridge_pkg::CMD_IO_EN] :
                        cmd[s1_side][bridge_pkg::CMD_MEM_EN];
    master_ok = (s1_side == bridge_pkg::SIDE_EXT) ?
                (port_master_en && cmd[bridge_pkg::SIDE_INT][bridge_pkg::CMD_MASTER_EN]) :
                cmd[bridge_pkg::SIDE_EXT][bridge_pkg::CMD_MASTER_EN];
    next_fwd = 1'b0;
    next_ur = 1'b0;
    next_uc = 1'b0;
    next_set = '0;
    next_addr = 64'h0;
    next_req_id = 16'h0000;
    next_cpl_id = 16'h0000;
    if (s1_valid && s1_cpl) begin
      if (!link_ok || s1_id[7:4] != 4'h0 ||
          !tbl.cpl_data[bridge_pkg::ENT_VALID]) begin
        next_uc = 1'b1;
        next_set[bridge_pkg::STS_REV_MISS] = 1'b1;
      end else begin
        next_fwd = 1'b1;
        next_req_id = tbl.cpl_data[31:16];
        next_cpl_id = own_id[dst];
      end
    end else if (s1_valid) begin
      if (!access_ok || !master_ok) begin
        next_ur = 1'b1;
      end else if (!win_hit) begin
        next_ur = 1'b1;
        next_set[bridge_pkg::STS_WIN_MISS] = 1'b1;
      end else if (!link_ok || !tbl.srch_hit) begin
        next_ur = 1'b1;
        next_set[bridge_pkg::STS_FWD_MISS] = 1'b1;
      end else begin
        next_fwd = 1'b1;
        next_addr = win_xaddr;
        next_req_id = {own_id[dst][15:8], 4'h0, tbl.srch_idx};
      end
      next_set[bridge_pkg::STS_UNSUPPORTED] = next_ur;
    end
  end

  // status flags: hardware set wins over write-one-to-clear
  always_ff @(posedge mclk) begin
    for (int s = 0; s < bridge_pkg::SIDES; s++) begin
      logic [bridge_pkg::STS_W-1:0] clr;
      logic [bridge_pkg::STS_W-1:0] set;
      clr = '0;
      set = '0;
      if (reg_wr && side_sel == 1'(s) && ofs == bridge_pkg::OFS_STATUS) begin
        clr = reg_wdata[bridge_pkg::STS_W-1:0];
      end
      if (s1_side == 1'(s)) begin
        set = next_set;
      end
      if (tbl_odd_access && side_sel == 1'(s)) begin
        set[bridge_pkg::STS_TBL_ACCESS] = 1'b1;
      end
      if (srst) begin
        status[s] <= '0;
      end else if (ce) begin
        status[s] <= (status[s] & ~clr) | set;
      end
    end
  end

  // outgoing headers and error events
  always_ff @(posedge mclk) begin
    if (srst) begin
      fwd_valid <= 1'b0;
      fwd_side <= 1'b0;
      fwd_cpl <= 1'b0;
      fwd_addr <= 64'h0;
      fwd_req_id <= 16'h0000;
      fwd_cpl_id <= 16'h0000;
      ur_cpl_valid <= 1'b0;
      ur_side <= 1'b0;
      ur_req_id <= 16'h0000;
      err_msg <= 1'b0;
      uc_valid <= 1'b0;
    end else if (ce) begin
      fwd_valid <= next_fwd;
      fwd_side <= ~s1_side;
      fwd_cpl <= s1_cpl;
      fwd_addr <= next_addr;
      fwd_req_id <= next_req_id;
      fwd_cpl_id <= next_cpl_id;
      ur_cpl_valid <= next_ur && s1_np;
      ur_side <= s1_side;
      ur_req_id <= s1_id;
      err_msg <= (next_ur || next_uc) && cmd[s1_side][bridge_pkg::CMD_ERR_MSG_EN];
      uc_valid <= next_uc;
    end
  end
endmodule

// ===== sim/tlp_sink.sv
// tlp_sink: far-side root that accepts forwarded headers.
// assumes headers arrive as one-cycle pulses on mclk.
`timescale 1ns/100ps
module tlp_sink (
  // clock, reset
  input wire logic mclk,
  input wire logic srst,
  // forwarded header
  input wire logic fwd_valid,
  output logic [15:0] taken
);
  always_ff @(posedge mclk) begin
    if (srst) begin
      taken <= 16'h0000;
    end else if (fwd_valid) begin
      taken <= taken + 16'h0001;
    end
  end
endmodule

// ===== sim/ntb_address_translation_sva.sv
// ntb_address_translation_sva: port checks of the bridge.
// assumes ce stays high while traffic runs.
`timescale 1ns/100ps
module ntb_address_translation_sva (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  // watched ports
  input wire logic [7:0] reg_addr,
  input wire logic [3:0] reg_be,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic req_valid,
  input wire logic req_side,
  input wire logic req_np,
  input wire logic req_cpl,
  input wire logic [15:0] req_id,
  input wire logic fwd_valid,
  input wire logic fwd_side,
  input wire logic fwd_cpl,
  input wire logic [15:0] fwd_req_id,
  input wire logic ur_cpl_valid,
  input wire logic [15:0] ur_req_id,
  input wire logic uc_valid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst || !ce);
  sequence s_post; req_valid && !req_np && !req_cpl; endsequence
  sequence s_cpl; req_valid && req_cpl; endsequence
  sequence s_tbl; reg_rd && reg_addr[6:0] == bridge_pkg::OFS_TBL_DATA; endsequence
  property p_one; $onehot0({fwd_valid, ur_cpl_valid, uc_valid}); endproperty
  a_one: assert property (p_one) else $error("two outcomes at once");
  property p_ur;
    ur_cpl_valid |-> $past(req_valid && req_np && !req_cpl, 2) && ur_req_id == $past(req_id, 2);
  endproperty
  a_ur: assert property (p_ur) else $error("bad ur completion");
  property p_post; s_post |-> ##2 !ur_cpl_valid; endproperty
  a_post: assert property (p_post) else $error("ur completion for posted");
  property p_side; fwd_valid |-> fwd_side == !$past(req_side, 2); endproperty
  a_side: assert property (p_side) else $error("forward side wrong");
  property p_rid;
    fwd_valid && !fwd_cpl |-> fwd_req_id[7:4] == 4'h0 && $past(req_valid && !req_cpl, 2);
  endproperty
  a_rid: assert property (p_rid) else $error("index field wrong");
  property p_cpl; s_cpl |-> ##2 (fwd_valid ^ uc_valid) && !ur_cpl_valid; endproperty
  a_cpl: assert property (p_cpl) else $error("completion outcome wrong");
  property p_uc; uc_valid |-> $past(req_valid && req_cpl, 2); endproperty
  a_uc: assert property (p_uc) else $error("stray unexpected completion");
  property p_idle; !req_valid |-> ##2 !(fwd_valid || ur_cpl_valid || uc_valid); endproperty
  a_idle: assert property (p_idle) else $error("outcome without request");
  property p_byte; s_tbl and reg_be != bridge_pkg::BE_DWORD |=> reg_rdata == 32'h0; endproperty
  a_byte: assert property (p_byte) else $error("partial table read not zero");
  property p_ent;
    s_tbl and reg_be == bridge_pkg::BE_DWORD |=>
      reg_rdata[15:1] == 15'h0 && (reg_rdata[0] || reg_rdata[31:16] == 16'h0);
  endproperty
  a_ent: assert property (p_ent) else $error("table entry read wrong");
endmodule
bind ntb_address_translation ntb_address_translation_sva ntb_address_translation_sva_inst (
  .mclk(mclk), .srst(srst), .ce(ce), .reg_addr(reg_addr), .reg_be(reg_be), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .req_valid(req_valid), .req_side(req_side), .req_np(req_np),
  .req_cpl(req_cpl), .req_id(req_id), .fwd_valid(fwd_valid), .fwd_side(fwd_side),
  .fwd_cpl(fwd_cpl), .fwd_req_id(fwd_req_id), .ur_cpl_valid(ur_cpl_valid),
  .ur_req_id(ur_req_id), .uc_valid(uc_valid));

// ===== sim/tb_ntb_address_translation.sv
// tb_ntb_address_translation: register and header tests of the bridge.
// assumes outcomes two cycles after a request, read data one cycle after.
`timescale 1ns/100ps
module tb_ntb_address_translation;
  logic mclk, srst, ce, reg_wr, reg_rd, link_up, req_valid, req_side, req_io, req_np, req_cpl;
  logic fwd_valid, fwd_side, fwd_cpl, ur_cpl_valid, ur_side, err_msg, uc_valid;
  logic [7:0] reg_addr;
  logic [3:0] reg_be, out;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic [63:0] req_addr, fwd_addr;
  logic [15:0] req_id, fwd_req_id, fwd_cpl_id, ur_req_id, taken;
  int miscompares = 0;
  int samples_checked = 0;
  ntb_address_translation ntb_address_translation_inst (.mclk(mclk), .srst(srst), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_be(reg_be), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_up(link_up), .req_valid(req_valid),
    .req_side(req_side), .req_io(req_io), .req_np(req_np), .req_cpl(req_cpl),
    .req_addr(req_addr), .req_id(req_id), .fwd_valid(fwd_valid), .fwd_side(fwd_side),
    .fwd_cpl(fwd_cpl), .fwd_addr(fwd_addr), .fwd_req_id(fwd_req_id), .fwd_cpl_id(fwd_cpl_id),
    .ur_cpl_valid(ur_cpl_valid), .ur_side(ur_side), .ur_req_id(ur_req_id),
    .err_msg(err_msg), .uc_valid(uc_valid));
  tlp_sink tlp_sink_inst (.mclk(mclk), .srst(srst), .fwd_valid(fwd_valid), .taken(taken));
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    rd = reg_rdata;
  endtask
  // k = side, io, non-posted, completion
  task automatic req(input logic [3:0] k, input logic [63:0] a, input logic [15:0] id);
    @(posedge mclk);
    {req_valid, req_side, req_io, req_np, req_cpl} <= {1'b1, k};
    req_addr <= a;
    req_id <= id;
    @(posedge mclk);
    req_valid <= 1'b0;
    @(posedge mclk);
    #1;
    out = {fwd_valid, ur_cpl_valid, uc_valid, err_msg};
  endtask
  task automatic sts(input logic [7:0] a, input logic [31:0] exp);
    rd_reg(a);
    chk(rd, exp);
    wr(a, 32'h0000001F);
  endtask
  task automatic print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    #20000;
    miscompares++;
    print_verdict;
  end
  initial begin
    {srst, ce, link_up, reg_be} = {3'b111, 4'hF};
    {reg_wr, reg_rd, req_valid, req_side, req_io, req_np, req_cpl} = 7'h00;
    {reg_addr, reg_wdata, req_addr, req_id} = '0;
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    rd_reg(8'h0C);
    chk(rd, 32'h0);
    wr(8'h00, 32'h6);
    wr(8'h80, 32'h6);
    wr(8'h14, 32'h4);
    wr(8'h10, 32'h1100);
    wr(8'h90, 32'h2200);
    wr(8'h20, 32'h60); // one 4 KB window, no overlap
    wr(8'h30, 32'h80000ABC);
    wr(8'h48, 32'h00400000); // 32-bit to 32-bit
    wr(8'h58, 32'h004000FF);
    rd_reg(8'h30);
    chk(rd, 32'h80000000);
    wr(8'h08, 32'hE);
    wr(8'h0C, 32'h3315FFFF);
    wr(8'h88, 32'h3);
    wr(8'h8C, 32'hABCD0000);
    rd_reg(8'h8C);
    chk(rd, 32'h0);
    rd_reg(8'h0C);
    chk(rd, 32'h33150001);
    reg_be <= 4'h3;
    rd_reg(8'h0C);
    chk(rd, 32'h0);
    wr(8'h0C, 32'h0);
    reg_be <= 4'hF;
    rd_reg(8'h0C);
    chk(rd, 32'h33150001);
    sts(8'h04, 32'h1);
    req(4'b0000, 64'h80000ABC, 16'h3315);
    chk({out, fwd_side, fwd_addr, fwd_req_id}, {5'b10001, 64'h04000ABC, 16'h220E});
    req(4'b0000, 64'h80000FF0, 16'h3315);
    chk({out, fwd_addr}, {4'b1000, 64'h04000FF0});
    wr(8'h28, 32'h64); // windows two and three paired
    wr(8'h3C, 32'h1);
    wr(8'h54, 32'h2);
    wr(8'h60, 32'hFF);
    wr(8'h64, 32'h2);
    req(4'b0000, 64'h100000123, 16'h3315);
    chk({out, fwd_addr, fwd_req_id}, {4'b1000, 64'h200000123, 16'h220E});
    req(4'b0010, 64'h80000FF1, 16'h3315);
    chk({out, ur_side, ur_req_id}, {5'b01000, 16'h3315});
    sts(8'h04, 32'h18);
    req(4'b0010, 64'h80000000, 16'h3316);
    chk(out, 4'b0100);
    sts(8'h04, 32'h12);
    req(4'b0000, 64'h90000000, 16'h3315);
    chk(out, 4'b0000);
    sts(8'h04, 32'h18);
    req(4'b1001, 64'h0, 16'h220E);
    chk({out, fwd_cpl, fwd_side, fwd_req_id, fwd_cpl_id}, {6'h22, 32'h33151100});
    req(4'b1001, 64'h0, 16'h2203);
    chk(out, 4'b0010);
    sts(8'h84, 32'h4);
    wr(8'h00, 32'h104);
    req(4'b0000, 64'h80000ABC, 16'h3315);
    chk(out, 4'b0001);
    sts(8'h04, 32'h10);
    wr(8'h00, 32'h7);
    req(4'b0100, 64'h80000ABC, 16'h3315);
    chk(out, 4'b0000);
    sts(8'h04, 32'h18);
    wr(8'h80, 32'h2);
    req(4'b0010, 64'h80000ABC, 16'h3315);
    chk(out, 4'b0100);
    wr(8'h80, 32'h6);
    link_up <= 1'b0;
    sts(8'h04, 32'h10);
    req(4'b0000, 64'h80000ABC, 16'h3315);
    chk(out, 4'b0000);
    req(4'b0001, 64'h0, 16'h220E);
    chk(out, 4'b0010);
    sts(8'h04, 32'h16);
    chk(taken, 16'h4);
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    wr(8'h08, 32'hE);
    rd_reg(8'h0C);
    chk(rd, 32'h0);
    ce <= 1'b0;
    wr(8'h08, 32'h5);
    ce <= 1'b1;
    rd_reg(8'h08);
    chk(rd, 32'hE);
    print_verdict;
  end
endmodule
